// *** hdl/section_parser_pkg.sv ***
// Shared constants, types and register map for the private section parser
package section_parser_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_HDR0 = 8'h0C;
    localparam logic [7:0] OFS_HDR1 = 8'h10;
    localparam logic [7:0] OFS_REV = 8'h14;

    // Reset values
    localparam logic CTRL_EN_RST = 1'b1;
    localparam logic [4:0] MASK_RST = 5'h00;

    // Status and mask bit positions
    localparam int EV_GOOD = 0;
    localparam int EV_CRC = 1;
    localparam int EV_LEN = 2;
    localparam int EV_DONE = 3;
    localparam int EV_PEND = 4;
    localparam int EV_W = 5;

    // Section layout figures
    localparam logic [11:0] LEN_MAX = 12'hFFD;
    localparam logic [11:0] LONG_MIN = 12'h009;
    localparam logic [11:0] CRC_BYTES = 12'h004;
    localparam logic [2:0] LONG_HDR_LAST = 3'h4;
    localparam logic [7:0] TAG_RESERVED = 8'hFF;

    // Integrity check
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

    typedef enum logic [2:0] {
        ST_TAG,
        ST_LEN_HI,
        ST_LEN_LO,
        ST_LONG_HDR,
        ST_DATA
    } parse_e;

    // Byte arriving from the demultiplexer
    typedef struct packed {
        logic start;
        logic [7:0] data;
    } sec_in_s;

    // Payload byte handed onward
    typedef struct packed {
        logic last;
        logic good;
        logic [7:0] data;
    } sec_out_s;

    // Decoded header fields
    typedef struct packed {
        logic [7:0] table_tag;
        logic syntax;
        logic user_flag;
        logic [11:0] length;
        logic [15:0] table_tag_ext;
        logic [4:0] revision;
        logic applicable;
        logic [7:0] seg_index;
        logic [7:0] seg_final;
    } sec_hdr_s;

endpackage

// *** hdl/crc32_step.sv ***
// Bytewise MSB-first 32-bit cyclic redundancy check register
`timescale 1ns/1ps
`default_nettype none
module crc32_step (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic init,
    input wire logic en,
    input wire logic [7:0] data,
    output logic [31:0] crc_next
);
    import section_parser_pkg::*;

    typedef struct packed {
        logic [31:0] crc;
    } crc_state_s;

    crc_state_s r_reg;
    crc_state_s r_next;

    // One byte through the divider, top bit first
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] v;
        v = c;
        for (int i = 7; i >= 0; i--) begin
            if (v[31] ^ d[i]) begin
                v = {v[30:0], 1'b0} ^ CRC_POLY;
            end else begin
                v = {v[30:0], 1'b0};
            end
        end
        return v;
    endfunction

    // Start of section reloads all ones before the first byte
    always_comb begin
        r_next = r_reg;
        crc_next = crc_byte(init ? CRC_INIT : r_reg.crc, data);
        if (init || en) begin
            r_next.crc = crc_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '{crc: CRC_INIT};
        end else begin
            r_reg <= r_next;
        end
    end
endmodule
`default_nettype wire

// *** hdl/private_section_parser.sv ***
// Private section parser with APB registers and payload forwarding
//
// Operation
// - First byte is the 8-bit table tag; reserved tag values are flagged.
// - Syntax bit one selects long form with extension, revision and check word.
// - Syntax bit zero makes all bytes after the length opaque payload.
// - Twelve-bit length counts remaining bytes and marks the section end.
// - User flag bit is passed through without meaning.
// - Sixteen-bit tag extension is captured and forwarded uninterpreted.
// - Applicable bit one makes revision the table currently in force.
// - Applicable bit zero holds the revision pending as the next one.
// - Final segment index tells when every segment of the table arrived; tracked for applicable bit one only.
// - Check runs over the whole long section; accept only on zero residue.
// - All segments of one table carry the same table tag.
// - Long sections use the full common header after the shared fields.
`timescale 1ns/1ps
`default_nettype none
module private_section_parser #(
    parameter logic [11:0] MAX_LEN = 12'hFFD
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_valid,
    input wire section_parser_pkg::sec_in_s in_byte,
    output logic out_valid,
    output section_parser_pkg::sec_out_s out_byte,
    output section_parser_pkg::sec_hdr_s hdr,
    output logic hdr_valid,
    output logic irq
);
    import section_parser_pkg::*;

    typedef struct packed {
        parse_e st;
        logic [2:0] pos;
        logic [11:0] remain;
        sec_hdr_s hdr;
        logic hdr_valid;
        logic tag_reserved;
        logic enable;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic cur_valid;
        logic [4:0] cur_rev;
        logic pend_valid;
        logic [4:0] pend_rev;
        logic trk_valid;
        logic [7:0] trk_tag;
        logic [15:0] trk_ext;
        logic [4:0] trk_rev;
        logic [255:0] seen;
        logic [31:0] prdata;
        logic out_valid;
        sec_out_s out_byte;
    } parser_state_s;

    parser_state_s r_reg;
    parser_state_s r_next;

    logic crc_init;
    logic crc_en;
    logic [31:0] crc_next;

    // Bit for one segment index
    function automatic logic [255:0] seg_bit(input logic [7:0] idx);
        return 256'h1 << idx;
    endfunction

    // Bits of all segments from zero up to the final index
    function automatic logic [255:0] seg_upto(input logic [7:0] last);
        logic [255:0] m;
        m = '0;
        for (int i = 0; i < 256; i++) begin
            m[i] = (i <= int'(last));
        end
        return m;
    endfunction

    // Address decode for the error answer; the read mux decodes paddr in its own case
    function automatic logic is_mapped(input logic [7:0] a);
        return (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_MASK) ||
               (a == OFS_HDR0) || (a == OFS_HDR1) || (a == OFS_REV);
    endfunction

    crc32_step u_crc (
        .pclk(pclk),
        .presetn(presetn),
        .init(crc_init),
        .en(crc_en),
        .data(in_byte.data),
        .crc_next(crc_next)
    );

    // Zero wait state slave; read data is prepared in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign prdata = r_reg.prdata;
    assign out_valid = r_reg.out_valid;
    assign out_byte = r_reg.out_byte;
    assign hdr = r_reg.hdr;
    assign hdr_valid = r_reg.hdr_valid;
    assign irq = |(r_reg.status & r_reg.mask);

    // Parser, table tracking and register file in one next-state process
    always_comb begin
        logic [EV_W-1:0] ev;
        logic [11:0] len_v;
        logic sec_end;
        logic sec_ok;
        logic [255:0] seen_v;
        ev = '0;
        len_v = '0;
        sec_end = 1'b0;
        sec_ok = 1'b0;
        seen_v = '0;
        r_next = r_reg;
        r_next.out_valid = 1'b0;
        r_next.out_byte = '0;
        r_next.hdr_valid = 1'b0;
        crc_init = 1'b0;
        crc_en = 1'b0;

        if (in_valid && r_reg.enable) begin
            if (in_byte.start) begin
                if (r_reg.st != ST_TAG) begin
                    ev[EV_LEN] = 1'b1;
                end
                // first byte is the table tag
                r_next.hdr = '0;
                r_next.hdr.table_tag = in_byte.data;
                r_next.tag_reserved = (in_byte.data == TAG_RESERVED);
                r_next.st = ST_LEN_HI;
                crc_init = 1'b1;
            end else begin
                unique case (r_reg.st)
                    ST_TAG: begin
                        // Stray bytes outside a section are dropped
                    end
                    ST_LEN_HI: begin
                        crc_en = 1'b1;
                        r_next.hdr.syntax = in_byte.data[7];
                        r_next.hdr.user_flag = in_byte.data[6];
                        r_next.hdr.length[11:8] = in_byte.data[3:0];
                        r_next.st = ST_LEN_LO;
                    end
                    ST_LEN_LO: begin
                        crc_en = 1'b1;
                        len_v = {r_reg.hdr.length[11:8], in_byte.data};
                        r_next.hdr.length = len_v;
                        r_next.remain = len_v;
                        r_next.pos = '0;
                        if (len_v > MAX_LEN || (r_reg.hdr.syntax && len_v < LONG_MIN)) begin
                            ev[EV_LEN] = 1'b1;
                            r_next.st = ST_TAG;
                        end else if (len_v == 12'h000) begin
                            // Empty short section ends at its header
                            r_next.hdr_valid = 1'b1;
                            ev[EV_GOOD] = 1'b1;
                            r_next.st = ST_TAG;
                        end else if (r_reg.hdr.syntax) begin
                            r_next.st = ST_LONG_HDR;
                        end else begin
                            r_next.hdr_valid = 1'b1;
                            r_next.st = ST_DATA;
                        end
                    end
                    ST_LONG_HDR: begin
                        crc_en = 1'b1;
                        r_next.remain = r_reg.remain - 12'h001;
                        r_next.pos = r_reg.pos + 3'h1;
                        // full common header in long form
                        unique case (r_reg.pos)
                            3'h0: r_next.hdr.table_tag_ext[15:8] = in_byte.data;
                            3'h1: r_next.hdr.table_tag_ext[7:0] = in_byte.data;
                            3'h2: begin
                                r_next.hdr.revision = in_byte.data[5:1];
                                r_next.hdr.applicable = in_byte.data[0];
                            end
                            3'h3: r_next.hdr.seg_index = in_byte.data;
                            default: r_next.hdr.seg_final = in_byte.data;
                        endcase
                        if (r_reg.pos == LONG_HDR_LAST) begin
                            r_next.hdr_valid = 1'b1;
                            r_next.st = ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        crc_en = 1'b1;
                        r_next.remain = r_reg.remain - 12'h001;
                        // count of remaining bytes finds the end
                        sec_end = (r_reg.remain == 12'h001);
                        // Check word bytes are not payload
                        if (!r_reg.hdr.syntax || r_reg.remain > CRC_BYTES) begin
                            r_next.out_valid = 1'b1;
                            r_next.out_byte.data = in_byte.data;
                            r_next.out_byte.last = sec_end || (r_reg.hdr.syntax &&
                                                   r_reg.remain == CRC_BYTES + 12'h001);
                        end
                        if (sec_end) begin
                            r_next.st = ST_TAG;
                            // residue after the check word must be zero
                            // nonzero residue raises the check error
                            sec_ok = !r_reg.hdr.syntax || (crc_next == 32'h00000000);
                            ev[EV_GOOD] = sec_ok;
                            ev[EV_CRC] = !sec_ok;
                        end
                        // Short form verdict rides with the last byte
                        r_next.out_byte.good = r_next.out_byte.last &&
                                               !r_reg.hdr.syntax;
                    end
                    default: r_next.st = ST_TAG;
                endcase
            end
        end

        // Accepted long section updates revision and segment tracking
        if (sec_ok && r_reg.hdr.syntax) begin
            if (r_reg.hdr.applicable) begin
                r_next.cur_valid = 1'b1;
                r_next.cur_rev = r_reg.hdr.revision;
                if (r_reg.pend_valid && r_reg.pend_rev == r_reg.hdr.revision) begin
                    r_next.pend_valid = 1'b0;
                end
                // a change of tag, extension or revision starts a new table
                if (r_reg.trk_valid && r_reg.trk_tag == r_reg.hdr.table_tag &&
                    r_reg.trk_ext == r_reg.hdr.table_tag_ext &&
                    r_reg.trk_rev == r_reg.hdr.revision) begin
                    seen_v = r_reg.seen | seg_bit(r_reg.hdr.seg_index);
                end else begin
                    seen_v = seg_bit(r_reg.hdr.seg_index);
                end
                r_next.seen = seen_v;
                r_next.trk_valid = 1'b1;
                r_next.trk_tag = r_reg.hdr.table_tag;
                r_next.trk_ext = r_reg.hdr.table_tag_ext;
                r_next.trk_rev = r_reg.hdr.revision;
                // all segments up to the final index present
                ev[EV_DONE] = &(seen_v | ~seg_upto(r_reg.hdr.seg_final));
            end else begin
                r_next.pend_valid = 1'b1;
                r_next.pend_rev = r_reg.hdr.revision;
                ev[EV_PEND] = 1'b1;
            end
        end

        // Long-form payload's last byte always carries good low; the check result goes to status only
        if (r_next.out_byte.last && r_reg.hdr.syntax) begin
            r_next.out_byte.good = 1'b0;
        end

        // Register reads prepared in setup; status read clears, set wins
        r_next.status = r_reg.status;
        if (psel && penable && !pwrite && paddr == OFS_STATUS) begin
            r_next.status = '0;
        end
        r_next.status = r_next.status | ev;
        if (psel && !penable) begin
            unique case (paddr)
                OFS_CTRL: r_next.prdata = {31'h0, r_reg.enable};
                // Same-cycle events included, else the coming clear would lose them
                OFS_STATUS: r_next.prdata = {27'h0, r_next.status};
                OFS_MASK: r_next.prdata = {27'h0, r_reg.mask};
                OFS_HDR0: r_next.prdata = {r_reg.hdr.table_tag, r_reg.hdr.syntax,
                                           r_reg.hdr.user_flag, r_reg.tag_reserved,
                                           9'h000, r_reg.hdr.length};
                OFS_HDR1: r_next.prdata = {r_reg.hdr.table_tag_ext, r_reg.hdr.seg_index,
                                           r_reg.hdr.seg_final};
                OFS_REV: r_next.prdata = {16'h0000, r_reg.cur_valid, 2'h0, r_reg.cur_rev,
                                          r_reg.pend_valid, 2'h0, r_reg.pend_rev};
                default: r_next.prdata = 32'h00000000;
            endcase
        end
        if (psel && penable && pwrite) begin
            if (paddr == OFS_CTRL) begin
                r_next.enable = pwdata[0];
            end
            if (paddr == OFS_MASK) begin
                r_next.mask = pwdata[EV_W-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.st <= ST_TAG;
            r_reg.enable <= CTRL_EN_RST;
            r_reg.mask <= MASK_RST;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule
`default_nettype wire

// *** verification/private_section_parser_sva.sv ***
// Port-level assertions for the private section parser
`timescale 1ns/1ps
`default_nettype none
module parser_sva #(
    parameter logic [11:0] MAX_LEN = 12'hFFD
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic in_valid,
    input wire section_parser_pkg::sec_in_s in_byte,
    input wire logic out_valid,
    input wire section_parser_pkg::sec_out_s out_byte,
    input wire section_parser_pkg::sec_hdr_s hdr,
    input wire logic hdr_valid
);
    import section_parser_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Zero wait states, refusal only off the map
    a_access_ready: assert property (psel && penable |-> pready) else $error("no ready");
    a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > OFS_REV)) else $error("bad slave error");
    a_len_bound: assert property (hdr_valid |-> hdr.length <= MAX_LEN)
        else $error("length over limit accepted");
    a_long_min: assert property (hdr_valid && hdr.syntax |-> hdr.length >= LONG_MIN)
        else $error("short long-form accepted");
    a_hdr_pulse: assert property (hdr_valid |=> !hdr_valid) else $error("header pulse long");
    a_out_cause: assert property (out_valid |-> $past(in_valid))
        else $error("payload without input byte");
    a_good_short: assert property (out_valid && out_byte.good |-> out_byte.last && !hdr.syntax)
        else $error("good flag misplaced");
    a_hdr_hold: assert property (!$past(in_valid) |-> $stable(hdr))
        else $error("header moved without input");
    a_last_end: assert property (out_valid && out_byte.last |-> ##1 !out_valid ##1 !out_valid)
        else $error("payload after section end");
endmodule
`default_nettype wire

// *** verification/section_source.sv ***
// Byte source standing in for the demultiplexer
`timescale 1ns/1ps
`default_nettype none
module section_source (
    input wire logic pclk,
    output logic in_valid,
    output section_parser_pkg::sec_in_s in_byte
);
    import section_parser_pkg::*;
    initial begin
        in_valid = 1'b0;
        in_byte = '0;
    end
    // Idle cycles scramble data so stale bytes never look valid
    task automatic idle();
        @(posedge pclk);
        in_valid <= 1'b0;
        in_byte <= '{start: 1'b0, data: ~in_byte.data};
    endtask
    // One byte after an optional stall, held back to back otherwise
    task automatic put(input logic st, input logic [7:0] d, input int gap);
        repeat (gap) idle();
        @(posedge pclk);
        in_valid <= 1'b1;
        in_byte <= '{start: st, data: d};
    endtask
endmodule
`default_nettype wire

// *** verification/private_section_parser_bench.sv ***
// Self-checking bench for the private section parser
`timescale 1ns/1ps
`default_nettype none
module private_section_parser_bench;
    import section_parser_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, in_valid, out_valid, hdr_valid, irq;
    sec_in_s in_byte;
    sec_out_s out_byte;
    sec_hdr_s hdr;
    int fail_count = 0, checks = 0, cycles = 0;
    logic [31:0] exp_rd[$];
    sec_out_s exp_out[$];
    logic [7:0] exp_tag[$];
    logic [7:0] sec[$];
    logic [7:0] tag;
    logic [15:0] ext;
    logic [4:0] rev;
    always #4 pclk = ~pclk;
    private_section_parser i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_byte(in_byte), .out_valid(out_valid),
        .out_byte(out_byte), .hdr(hdr), .hdr_valid(hdr_valid), .irq(irq));
    section_source i_src (.pclk(pclk), .in_valid(in_valid), .in_byte(in_byte));
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // One APB transfer; for a read, d is the expected word
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) exp_rd.push_back(d);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Reference check register, MSB first, no reflection
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
        logic fb;
        for (int i = 7; i >= 0; i--) begin
            fb = c[31] ^ b[i];
            c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0);
        end
        return c;
    endfunction
    // Builds a section, notes expected payload and streams it with random stalls
    task automatic send(input logic syn, input logic flag, input logic [11:0] len,
        input logic [39:0] lh, input int n, input logic [31:0] bad, input logic fwd);
        logic [31:0] c;
        logic [7:0] b;
        sec = {};
        tag = 8'($urandom_range(254));
        sec.push_back(tag);
        if (fwd) exp_tag.push_back(tag);
        sec.push_back({syn, flag, 2'b11, len[11:8]});
        sec.push_back(len[7:0]);
        if (syn) for (int i = 4; i >= 0; i--) sec.push_back(lh[i*8+:8]);
        for (int i = 0; i < n; i++) begin
            b = 8'($urandom);
            sec.push_back(b);
            if (fwd) exp_out.push_back('{last: i == n - 1, good: i == n - 1 && !syn, data: b});
        end
        c = CRC_INIT;
        foreach (sec[i]) c = crc_byte(c, sec[i]);
        c = c ^ bad;
        if (syn) for (int i = 3; i >= 0; i--) sec.push_back(c[i*8+:8]);
        foreach (sec[i]) i_src.put(i == 0, sec[i], $urandom_range(2));
        i_src.idle();
        repeat (3) @(posedge pclk);
    endtask
    // Output and read-data watcher, plus the hang limit
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            fail_count++;
            finish_test();
        end
        if (psel && penable && pready === 1'b1 && !pwrite) compare(prdata, exp_rd.pop_front());
        if (out_valid === 1'b1) compare({22'h0, out_byte},
            exp_out.size() ? {22'h0, exp_out.pop_front()} : 32'hFFFFFFFF);
        if (hdr_valid === 1'b1) compare({24'h0, hdr.table_tag},
            exp_tag.size() ? {24'h0, exp_tag.pop_front()} : 32'hFFFFFFFF);
        if (psel && penable && pready === 1'b1) compare({31'h0, pslverr}, {31'h0, paddr > OFS_REV});
    end
    initial begin
        void'($urandom(3458));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h1);
        apb(1'b0, OFS_MASK, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        send(1'b0, 1'b1, 12'h002, 40'h0, 2, 32'h0, 1'b1);
        apb(1'b0, OFS_HDR0, {tag, 1'b0, 1'b1, 1'b0, 9'h0, 12'h002});
        apb(1'b0, OFS_STATUS, 32'h1 << EV_GOOD);
        apb(1'b0, OFS_STATUS, 32'h0);
        ext = 16'($urandom);
        rev = 5'($urandom);
        // first segment numbered zero, final zero
        send(1'b1, 1'b0, 12'h00C, {ext, 2'b11, rev, 1'b1, 16'h0000}, 3, 32'h0, 1'b1);
        apb(1'b0, OFS_STATUS, (32'h1 << EV_GOOD) | (32'h1 << EV_DONE));
        apb(1'b0, OFS_HDR1, {ext, 16'h0000});
        apb(1'b0, OFS_REV, {16'h0, 1'b1, 2'b00, rev, 8'h00});
        // next revision one up, held pending
        send(1'b1, 1'b0, LONG_MIN, {ext, 2'b11, rev + 5'h01, 1'b0, 16'h0000}, 0, 32'h0, 1'b1);
        apb(1'b0, OFS_STATUS, (32'h1 << EV_GOOD) | (32'h1 << EV_PEND));
        apb(1'b0, OFS_REV, {16'h0, 1'b1, 2'b00, rev, 1'b1, 2'b00, rev + 5'h01});
        send(1'b1, 1'b0, 12'h00A, {ext, 2'b11, rev, 1'b1, 16'h0000}, 1, 32'h1, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h1 << EV_CRC);
        apb(1'b1, OFS_MASK, 32'h1 << EV_LEN);
        send(1'b0, 1'b0, 12'hFFE, 40'h0, 0, 32'h0, 1'b0);
        send(1'b1, 1'b0, 12'h008, 40'h0, 0, 32'h0, 1'b0);
        compare(irq, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h1 << EV_LEN);
        @(negedge pclk);
        compare(irq, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h0);
        send(1'b0, 1'b0, 12'h001, 40'h0, 1, 32'h0, 1'b0);
        apb(1'b0, OFS_STATUS, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h1);
        // reserved tag flagged, in an empty short section
        tag = TAG_RESERVED;
        exp_tag.push_back(tag);
        i_src.put(1'b1, tag, 0);
        i_src.put(1'b0, 8'h30, 0);
        i_src.put(1'b0, 8'h00, 0);
        i_src.idle();
        repeat (3) @(posedge pclk);
        apb(1'b0, OFS_HDR0, {tag, 3'b001, 9'h0, 12'h000});
        apb(1'b0, OFS_STATUS, 32'h1 << EV_GOOD);
        repeat (2) @(posedge pclk);
        compare(exp_out.size() + exp_rd.size() + exp_tag.size(), 32'h0);
        finish_test();
    end
endmodule
bind private_section_parser parser_sva #(.MAX_LEN(MAX_LEN)) i_sva (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_byte(in_byte), .out_valid(out_valid),
    .out_byte(out_byte), .hdr(hdr), .hdr_valid(hdr_valid));
`default_nettype wire
